// [lsg_defines.svh]
/*
  register offsets, field positions, reset values and timing figures for the lfsr sequence generator.
  assumes inclusion by bare name from the design modules, the monitor and the testbench.
*/
`ifndef LSG_DEFINES_SVH
`define LSG_DEFINES_SVH

// byte-wide registers except the route register, one aligned 32-bit word each
`define LSG_SHIFT_LO_OFS    12'h000
`define LSG_SHIFT_MID_OFS   12'h004
`define LSG_SHIFT_HI_OFS    12'h008
`define LSG_POLY_LO_OFS     12'h00C
`define LSG_POLY_MID_OFS    12'h010
`define LSG_POLY_HI_OFS     12'h014
`define LSG_SEED_LO_OFS     12'h018
`define LSG_SEED_MID_OFS    12'h01C
`define LSG_SEED_HI_OFS     12'h020
`define LSG_CTRL_OFS        12'h024
`define LSG_CFG_OFS         12'h028
`define LSG_ROUTE_OFS       12'h02C

`define LSG_RUN_BIT         0
`define LSG_CLK_SEL_LSB     0
`define LSG_SYNC_LSB        4
`define LSG_CMP_LSB         6
`define LSG_SER_ROUTE_LSB   0
`define LSG_CMP_ROUTE_LSB   8

`define LSG_RESET_BYTE      8'h00
`define LSG_ROUTE_OFF       5'h00
`define LSG_CMPR_OFF        3'h0

`define LSG_RESP_OKAY       2'b00
`define LSG_RESP_SLVERR     2'b10

// clock period in ns, and the system clock period the generator models
`define LSG_CLK_NS          10
`define LSG_SYS24_NS        42
`define LSG_SYS24_DIV       ((`LSG_SYS24_NS + `LSG_CLK_NS - 1) / `LSG_CLK_NS)
`define LSG_SYS48_DIV       ((`LSG_SYS24_DIV + 1) / 2)

`endif

// [lsg_pkg.sv]
/*
  types shared by the lfsr sequence generator modules.
  assumes lsg_defines.svh is on the include path.
*/
package lsg_pkg;
  typedef enum logic [1:0] {
    LSG_CMP_EQ = 2'b00,
    LSG_CMP_LE = 2'b01,
    LSG_CMP_LT = 2'b10
  } lsg_cmp_type;

  typedef enum logic [1:0] {
    LSG_SYNC_SYS      = 2'b00,
    LSG_SYNC_SYS2     = 2'b01,
    LSG_SYNC_DIRECT   = 2'b10,
    LSG_SYNC_NONE     = 2'b11
  } lsg_sync_type;

  // axi-lite write handshake, gray along idle -> respond
  typedef enum logic [1:0] {
    LSG_WR_IDLE = 2'b00,
    LSG_WR_RESP = 2'b01
  } lsg_wr_state_type;
endpackage

// [lsg_step_gen.sv]
/*
  shift-enable generator: selects one of 16 clock sources, applies the sync mode, emits one-cycle step pulses.
  assumes source levels synchronous to clk_sys; the 48 MHz rate is approximated by the clk_sys divider.
*/
`timescale 1ns/10ps
`include "lsg_defines.svh"

module lsg_step_gen
#(
  parameter int DIVW = 16
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  clk_sel,
  input  wire logic [1:0]  sync_sel,
  input  wire logic        slow_32k_clock,
  input  wire logic        divided_clock_one,
  input  wire logic        divided_clock_two,
  input  wire logic [11:0] block_clocks,
  output logic             step
);
  logic [DIVW-1:0] cnt24_q;
  logic [DIVW-1:0] cnt48_q;
  logic [15:0]     src_vec;
  logic            src_lvl;
  logic            src_q;
  logic            rise;
  logic            tick24;
  logic            tick48;
  logic            step_q;
  logic            s24_q;
  logic            s48_q;
  logic            rise24;
  logic            rise48;

  assign tick24  = (cnt24_q == DIVW'(`LSG_SYS24_DIV - 1));
  assign tick48  = (cnt48_q == DIVW'(`LSG_SYS48_DIV - 1));
  // source 0 is the 48 MHz clock, seen here as its tick
  assign src_vec = {block_clocks, divided_clock_two, divided_clock_one, slow_32k_clock, tick48};
  assign src_lvl = src_vec[clk_sel];
  assign rise    = src_lvl & ~src_q;
  // resync looks at the source only on a tick, so a level held past one tick is never lost
  assign rise24  = tick24 & src_lvl & ~s24_q;
  assign rise48  = tick48 & src_lvl & ~s48_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt24_q <= '0;
      cnt48_q <= '0;
      src_q   <= 1'b0;
      s24_q   <= 1'b0;
      s48_q   <= 1'b0;
      step_q  <= 1'b0;
    end
    else
    begin
      cnt24_q <= tick24 ? '0 : cnt24_q + 1'b1;
      cnt48_q <= tick48 ? '0 : cnt48_q + 1'b1;
      src_q   <= src_lvl;
      if (tick24)
        s24_q <= src_lvl;
      if (tick48)
        s48_q <= src_lvl;
      case (sync_sel)
        lsg_pkg::LSG_SYNC_SYS:    step_q <= (clk_sel == 4'h0) ? tick48 : rise24;
        lsg_pkg::LSG_SYNC_SYS2:   step_q <= (clk_sel == 4'h0) ? tick48 : rise48;
        lsg_pkg::LSG_SYNC_DIRECT: step_q <= tick24;
        lsg_pkg::LSG_SYNC_NONE:   step_q <= (clk_sel == 4'h0) ? tick48 : rise;
        default:                  step_q <= 1'b0;
      endcase
    end
  end

  assign step = step_q;
endmodule // lsg_step_gen

// [lsg_top.sv]
/*
  lfsr sequence generator: 24-bit modular lfsr with seed compare, reached over axi4-lite.
  assumes clk_sys at 100 MHz, synchronous active-high rst, and a bus master that keeps axi4-lite handshakes.
*/
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
// What this block does
// - shift clock taken from one of 16 sources: 48M, 32k, divided clocks, blocks.
// - serial output disabled or routed onto one of sixteen global lines.
// - each enabled step compares the next shift value against seed; result drives compare output.
// - compare modes: equal, less-or-equal, or strictly less than seed.
// - compare output is active high, disabled or routed to one of four global lines.
// - four sync choices: sync to 24M, sync to 48M, direct 24M, none.
// - direct mode clocks from 24M system clock, ignoring clock source selection.
// - seed write while stopped also loads the shift register.
// - seed write while running changes only the compare value.
// - modular form: each stage above bit 0 XORs previous stage with gated final-stage output; bit 0 takes it alone.
// - each enabled step advances the register; top tap drives serial output.
// - reading the shift register copies it into the seed register, unless a seed write lands in the same cycle.
// - control bit 0 is the run bit; generator advances only when set.
`timescale 1ns/10ps
`include "lsg_defines.svh"

module lsg_top
#(
  parameter int WIDTH = 24
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        slow_32k_clock,
  input  wire logic        divided_clock_one,
  input  wire logic        divided_clock_two,
  input  wire logic [11:0] block_clocks,
  output logic [15:0]      serial_global_out,
  output logic [3:0]       compare_global_out
);
  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] poly_q;
  logic [WIDTH-1:0] seed_q;
  logic             run_q;
  logic [3:0]       clk_sel_q;
  logic [1:0]       clock_sync_select_q;
  logic [1:0]       compare_mode_select_q;
  logic [4:0]       serial_output_route_q;
  logic [2:0]       compare_output_route_q;
  logic             cmp_q;
  logic [15:0]      ser_out_q;
  logic [3:0]       cmp_out_q;

  logic             awready_q;
  logic             wready_q;
  logic             arready_q;
  logic [11:0]      awaddr_q;
  logic [31:0]      wdata_q;
  logic             wbyte0_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;

  logic             step;
  logic             wr_go;
  logic             rd_go;
  logic             wr_hit;
  logic             rd_hit;
  logic [7:0]       wb;
  logic [WIDTH-1:0] shift_next;
  logic             cmp_now;
  logic [31:0]      rd_mux;

  // byte lane select of a 24-bit register
  function automatic logic [7:0] byte_of(input logic [WIDTH-1:0] v, input int idx);
    logic [23:0] w;
    w = 24'(v);
    byte_of = w[idx*8 +: 8];
  endfunction

  // map a written byte into one lane of a 24-bit register
  function automatic logic [WIDTH-1:0] put_byte(input logic [WIDTH-1:0] v, input int idx, input logic [7:0] b);
    logic [23:0] w;
    w = 24'(v);
    w[idx*8 +: 8] = b;
    put_byte = WIDTH'(w);
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    is_reg = (a[1:0] == 2'b00) && (a <= `LSG_ROUTE_OFS);
  endfunction

  lsg_step_gen lsg_step_gen_inst
  (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .clk_sel           (clk_sel_q),
    .sync_sel          (clock_sync_select_q),
    .slow_32k_clock    (slow_32k_clock),
    .divided_clock_one (divided_clock_one),
    .divided_clock_two (divided_clock_two),
    .block_clocks      (block_clocks),
    .step              (step)
  );

  // ---- lfsr datapath ----
  // modular form: bit 0 takes the gated output, every other stage xors the gated output into the previous stage
  assign shift_next = {shift_q[WIDTH-2:0], 1'b0} ^ (poly_q & {WIDTH{shift_q[WIDTH-1]}});

  assign cmp_now = (compare_mode_select_q == lsg_pkg::LSG_CMP_EQ) ? (shift_next == seed_q) :
                   (compare_mode_select_q == lsg_pkg::LSG_CMP_LE) ? (shift_next <= seed_q) :
                   (compare_mode_select_q == lsg_pkg::LSG_CMP_LT) ? (shift_next <  seed_q) : 1'b0;

  // ---- axi4-lite write path ----
  assign wr_go  = !awready_q && !wready_q && !bvalid_q;
  assign wr_hit = is_reg(awaddr_q) && wbyte0_q;
  assign wb     = wdata_q[7:0];

  // ---- axi4-lite read path ----
  assign rd_go  = s_axi_arvalid && arready_q;
  assign rd_hit = is_reg(s_axi_araddr);
  assign rd_mux =
    (s_axi_araddr == `LSG_SHIFT_LO_OFS)  ? {24'h00_0000, byte_of(shift_q, 0)} :
    (s_axi_araddr == `LSG_SHIFT_MID_OFS) ? {24'h00_0000, byte_of(shift_q, 1)} :
    (s_axi_araddr == `LSG_SHIFT_HI_OFS)  ? {24'h00_0000, byte_of(shift_q, 2)} :
    (s_axi_araddr == `LSG_POLY_LO_OFS)   ? {24'h00_0000, byte_of(poly_q, 0)} :
    (s_axi_araddr == `LSG_POLY_MID_OFS)  ? {24'h00_0000, byte_of(poly_q, 1)} :
    (s_axi_araddr == `LSG_POLY_HI_OFS)   ? {24'h00_0000, byte_of(poly_q, 2)} :
    (s_axi_araddr == `LSG_SEED_LO_OFS)   ? {24'h00_0000, byte_of(seed_q, 0)} :
    (s_axi_araddr == `LSG_SEED_MID_OFS)  ? {24'h00_0000, byte_of(seed_q, 1)} :
    (s_axi_araddr == `LSG_SEED_HI_OFS)   ? {24'h00_0000, byte_of(seed_q, 2)} :
    (s_axi_araddr == `LSG_CTRL_OFS)      ? {31'h0000_0000, run_q} :
    (s_axi_araddr == `LSG_CFG_OFS)       ? {24'h00_0000, compare_mode_select_q, clock_sync_select_q, clk_sel_q} :
    (s_axi_araddr == `LSG_ROUTE_OFS)     ? {21'h00_0000, compare_output_route_q, 3'h0, serial_output_route_q} :
    32'h0000_0000;

  wire shift_rd_hit = rd_go && ((s_axi_araddr == `LSG_SHIFT_LO_OFS) || (s_axi_araddr == `LSG_SHIFT_MID_OFS) ||
                                (s_axi_araddr == `LSG_SHIFT_HI_OFS));

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wbyte0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `LSG_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `LSG_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
        wbyte0_q <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        bvalid_q  <= 1'b1;
        bresp_q   <= is_reg(awaddr_q) ? `LSG_RESP_OKAY : `LSG_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        // slots reopen only once the answer is taken, so one write at most is under way
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      if (rd_go)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? `LSG_RESP_OKAY : `LSG_RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_arready = arready_q;

  // ---- register file and generator state ----
  wire seed_wr = wr_go && wr_hit && ((awaddr_q == `LSG_SEED_LO_OFS) || (awaddr_q == `LSG_SEED_MID_OFS) ||
                                     (awaddr_q == `LSG_SEED_HI_OFS));
  wire [1:0] seed_idx = (awaddr_q == `LSG_SEED_LO_OFS) ? 2'd0 : (awaddr_q == `LSG_SEED_MID_OFS) ? 2'd1 : 2'd2;
  wire [WIDTH-1:0] seed_new = put_byte(seed_q, int'(seed_idx), wb);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      shift_q                <= '0;
      poly_q                 <= '0;
      seed_q                 <= '0;
      run_q                  <= 1'b0;
      clk_sel_q              <= 4'h0;
      clock_sync_select_q    <= 2'b00;
      compare_mode_select_q  <= 2'b00;
      serial_output_route_q  <= `LSG_ROUTE_OFF;
      compare_output_route_q <= `LSG_CMPR_OFF;
      cmp_q                  <= 1'b0;
    end
    else
    begin
      if (run_q && step)
      begin
        shift_q <= shift_next;
        cmp_q   <= cmp_now;
      end
      if (seed_wr)
      begin
        seed_q <= seed_new;
        if (!run_q)
          shift_q <= seed_new;
      end
      else if (shift_rd_hit)
        seed_q <= shift_q;
      if (wr_go && wr_hit)
      begin
        case (awaddr_q)
          `LSG_POLY_LO_OFS:  poly_q <= put_byte(poly_q, 0, wb);
          `LSG_POLY_MID_OFS: poly_q <= put_byte(poly_q, 1, wb);
          `LSG_POLY_HI_OFS:  poly_q <= put_byte(poly_q, 2, wb);
          `LSG_CTRL_OFS:     run_q <= wb[`LSG_RUN_BIT];
          `LSG_CFG_OFS:
          begin
            clk_sel_q             <= wb[`LSG_CLK_SEL_LSB +: 4];
            clock_sync_select_q   <= wb[`LSG_SYNC_LSB +: 2];
            compare_mode_select_q <= wb[`LSG_CMP_LSB +: 2];
          end
          `LSG_ROUTE_OFS:
          begin
            serial_output_route_q  <= wdata_q[`LSG_SER_ROUTE_LSB +: 5];
            compare_output_route_q <= wdata_q[`LSG_CMP_ROUTE_LSB +: 3];
          end
          default: ;
        endcase
      end
    end
  end

  // routing: bit 4 of a serial route / bit 2 of a compare route enables, low bits pick the line
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ser_out_q <= 16'h0000;
      cmp_out_q <= 4'h0;
    end
    else
    begin
      ser_out_q <= serial_output_route_q[4] ?
                   (16'(shift_q[WIDTH-1]) << serial_output_route_q[3:0]) : 16'h0000;
      cmp_out_q <= compare_output_route_q[2] ? (4'(cmp_q) << compare_output_route_q[1:0]) : 4'h0;
    end
  end

  assign s_axi_bvalid       = bvalid_q;
  assign s_axi_bresp        = bresp_q;
  assign s_axi_rvalid       = rvalid_q;
  assign s_axi_rdata        = rdata_q;
  assign s_axi_rresp        = rresp_q;
  assign serial_global_out  = ser_out_q;
  assign compare_global_out = cmp_out_q;
endmodule // lsg_top

// [lsg_monitor.sv]
/*
  port checker for lsg_top: bus handshakes and routed outputs.
  assumes one clk_sys domain with synchronous rst; bound after the module.
*/
`timescale 1ns/10ps
`include "lsg_defines.svh"

module lsg_monitor
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] serial_global_out,
  input wire logic [3:0]  compare_global_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  AST_R_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_NONE:
    assert property (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready) |=> !s_axi_rvalid)
    else $error("read answer without request");
  AST_W_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_W_BLOCK:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("slot free during response");
  AST_BAD_READ:
    assert property (s_axi_rvalid && s_axi_rresp == `LSG_RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("refused read carries data");
  AST_SER_ONE:
    assert property ($onehot0(serial_global_out)) else $error("serial on several lines");
  AST_CMP_ONE:
    assert property ($onehot0(compare_global_out)) else $error("compare on several lines");
endmodule // lsg_monitor

bind lsg_top lsg_monitor lsg_monitor_inst (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .serial_global_out, .compare_global_out);

// [lsg_host_model.sv]
/*
  host side model: an axi4-lite master with one write and one read task.
  assumes callers enter the tasks just after a clk_sys edge.
*/
`timescale 1ns/10ps

module lsg_host_model
(
  input  wire logic        clk_sys,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  output logic             s_axi_rready
);
  initial
  begin
    s_axi_awaddr = '0;
    s_axi_awvalid = 0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 0;
    s_axi_bready = 0;
    s_axi_araddr = '0;
    s_axi_arvalid = 0;
    s_axi_rready = 0;
  end

  // the leading edge keeps a release and a new request out of one time step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        break;
      end
    end
  endtask
endmodule // lsg_host_model

// [testbench.sv]
/*
  self-checking bench for lsg_top: register access, seeding, stepping, compare and routing.
  assumes lsg_host_model as bus master; sources other than divided_clock_one stay quiet.
*/
`timescale 1ns/10ps
`include "lsg_defines.svh"

module testbench;
  localparam logic [23:0] POLY = 24'hD8_0000;
  localparam logic [23:0] SEED = 24'h80_0001;
  logic        clk_sys, rst, slow_32k_clock, divided_clock_one, divided_clock_two;
  logic [11:0] s_axi_awaddr, s_axi_araddr, block_clocks;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb, compare_global_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] serial_global_out;
  logic [23:0] v, e;
  int          fails, checks_done;

  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  lsg_top lsg_top_inst (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slow_32k_clock,
    .divided_clock_one, .divided_clock_two, .block_clocks, .serial_global_out, .compare_global_out);
  lsg_host_model lsg_host_model_inst (.clk_sys, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rready);

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    lsg_host_model_inst.wr(a, d, rsp);
  endtask

  task automatic r(input logic [11:0] a);
    lsg_host_model_inst.rd(a, rdv, rsp);
  endtask

  // top byte of every word stays zero
  task automatic w24(input logic [11:0] a, input logic [23:0] d);
    for (int i = 0; i < 3; i++) w(a + 12'(4 * i), {24'h00_0000, d[8 * i +: 8]});
  endtask

  task automatic r24(input logic [11:0] a, output logic [23:0] q);
    for (int i = 0; i < 3; i++)
    begin
      r(a + 12'(4 * i));
      q[8 * i +: 8] = rdv[7:0];
    end
  endtask

  // wide pulses so a 24 MHz resync never misses an edge
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      divided_clock_one <= 1;
      repeat (8) @(posedge clk_sys);
      divided_clock_one <= 0;
      repeat (8) @(posedge clk_sys);
    end
  endtask

  function automatic logic [23:0] nx(input logic [23:0] s);
    return {s[22:0], 1'b0} ^ ({24{s[23]}} & POLY);
  endfunction

  task automatic finish_test;
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    finish_test;
  end

  initial
  begin
    rst = 1;
    slow_32k_clock = 0;
    divided_clock_one = 0;
    divided_clock_two = 0;
    block_clocks = '0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    for (int i = 0; i < 12; i++)
    begin
      r(12'(4 * i));
      chk("reset value", rdv, 0);
    end
    r(12'h030);
    chk("unmapped read", {rdv[29:0], rsp}, {30'h0, `LSG_RESP_SLVERR});
    w(12'h030, 1);
    chk("unmapped write", 32'(rsp), 32'(`LSG_RESP_SLVERR));
    for (int m = 0; m < 3; m++)
    begin
      w(`LSG_CTRL_OFS, 0);
      w24(`LSG_POLY_LO_OFS, POLY);
      w24(`LSG_SEED_LO_OFS, SEED);
      r24(`LSG_SHIFT_LO_OFS, v);
      chk("seed load", v, SEED);
      pulse(2);
      r24(`LSG_SHIFT_LO_OFS, v);
      chk("stopped", v, SEED);
      w(`LSG_CFG_OFS, 32'(m << 6) | 2);
      w(`LSG_ROUTE_OFS, 32'h0000_0410 | 32'(m << 8) | 32'(m));
      e = SEED;
      for (int k = 0; k < 4 + m; k++) e = nx(e);
      w(`LSG_CTRL_OFS, 1);
      w24(`LSG_SEED_LO_OFS, e);
      pulse(4 + m);
      w(`LSG_CTRL_OFS, 0);
      chk("compare", 32'(compare_global_out), 32'(m < 2) << m);
      chk("serial", 32'(serial_global_out), 32'(e[23]) << m);
      r24(`LSG_SHIFT_LO_OFS, v);
      chk("sequence", v, e);
    end
    w24(`LSG_SEED_LO_OFS, SEED);
    w(`LSG_CFG_OFS, 32'h0000_0022);
    w(`LSG_CTRL_OFS, 1);
    repeat (20) @(posedge clk_sys);
    w(`LSG_CTRL_OFS, 0);
    r24(`LSG_SHIFT_LO_OFS, v);
    chk("direct clock", 32'(v != SEED), 1);
    r24(`LSG_SEED_LO_OFS, e);
    chk("read copy", e, v);
    finish_test;
  end
endmodule // testbench
